/* File: cmc_bus_model.sv */
`timescale 1ns/1ns
`default_nettype none
module cmc_bus_model (
    // Device pins
    input wire logic tx_pin,
    input wire logic tx_oe,
    // Other node on the bus
    input wire logic node_dom,
    // Bus level seen by the device
    output logic rx_pin
);
    // Wired-and bus, pulled recessive when idle
    assign rx_pin = ~(node_dom | (tx_oe & ~tx_pin));
endmodule : cmc_bus_model
`default_nettype wire

/* File: cmc_mode_checker.sv */
`timescale 1ns/1ns
`default_nettype none
module cmc_mode_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Watched ports
    input wire cmc_pkg::cmc_apb_req_t apb_req,
    input wire cmc_pkg::cmc_apb_rsp_t apb_rsp,
    input wire logic bus_transmit_pin,
    input wire logic bus_tx_oe,
    input wire logic eng_tx_en,
    input wire logic eng_ack_en,
    input wire logic eng_loopback,
    input wire logic eng_clk_run,
    input wire logic err_cnt_hold,
    input wire logic store_valid,
    input wire logic [4:0] data_filter_length,
    input wire logic [3:0] fifo_len
);
    import cmc_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    property p_setup; apb_req.psel && !apb_req.penable |=> apb_rsp.pready;
    endproperty
    a_setup: assert property (p_setup) else $error("no ready");
    property p_slp_pin; !eng_clk_run |-> bus_transmit_pin; endproperty
    a_slp_pin: assert property (p_slp_pin) else $error("pin");
    property p_slp_quiet; !eng_clk_run |-> !eng_tx_en && !store_valid;
    endproperty
    a_slp_quiet: assert property (p_slp_quiet) else $error("q");
    property p_loop; eng_loopback |-> !bus_tx_oe && !eng_ack_en; endproperty
    a_loop: assert property (p_loop) else $error("loop");
    property p_ack; eng_ack_en |-> eng_tx_en && !eng_loopback; endproperty
    a_ack: assert property (p_ack) else $error("ack");
    property p_hold; !eng_tx_en && eng_clk_run |-> err_cnt_hold; endproperty
    a_hold: assert property (p_hold) else $error("hold");
    property p_drive; !bus_transmit_pin |-> eng_ack_en; endproperty
    a_drive: assert property (p_drive) else $error("drive");
    property p_fifo; fifo_len >= 4'h2 && fifo_len <= CMC_FIFO_MAX; endproperty
    a_fifo: assert property (p_fifo) else $error("fifo");
    property p_dfl; data_filter_length <= CMC_DFL_MAX; endproperty
    a_dfl: assert property (p_dfl) else $error("dfl");
endmodule : cmc_mode_checker
bind cmc_mode_ctrl cmc_mode_checker u_chk (.clk(clk), .rstn(rstn),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .bus_transmit_pin(bus_transmit_pin),
    .bus_tx_oe(bus_tx_oe), .eng_tx_en(eng_tx_en), .eng_ack_en(eng_ack_en),
    .eng_loopback(eng_loopback), .eng_clk_run(eng_clk_run),
    .err_cnt_hold(err_cnt_hold), .store_valid(store_valid),
    .data_filter_length(data_filter_length), .fifo_len(fifo_len));
`default_nettype wire

/* File: cmc_mode_ctrl.sv */
`timescale 1ns/1ns
`default_nettype none

module cmc_mode_ctrl (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Register bus
    input wire cmc_pkg::cmc_apb_req_t apb_req,
    output cmc_pkg::cmc_apb_rsp_t apb_rsp,
    // Bus pins
    input wire logic bus_rx_pin,
    output logic bus_transmit_pin,
    output logic bus_tx_oe,
    // Protocol engine
    input wire cmc_pkg::cmc_eng_t eng,
    output logic eng_rx_bit,
    output logic eng_tx_en,
    output logic eng_ack_en,
    output logic eng_loopback,
    output logic eng_clk_run,
    output logic err_cnt_clear,
    output logic err_cnt_hold,
    // Filter routing
    output logic [31:0] flt_mask_sel,
    output logic [4:0] data_filter_length,
    output logic store_valid,
    output logic [3:0] store_buf,
    output logic [3:0] fifo_len,
    // Interrupt request for the wake flag
    output logic wake_irq
);
    import cmc_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Registers
    cmc_state_t state_reg;
    cmc_state_t prev_reg;
    logic [2:0] op_mode_request;
    logic [1:0] func_mode_reg;
    logic wake_disable;
    logic wake_irq_enable;
    logic mask_third_reg;
    logic wake_flag;
    logic [3:0] rx_buffer_mode_bits;
    logic [CMC_NPROG-1:0] tx_en_reg;
    logic [6:0] flt_link_reg [CMC_NFLT];
    logic [4:0] dfl_reg;
    logic [3:0] idle_cnt_reg;
    logic [3:0] fifo_wr_reg;
    logic rx_s1_reg;
    logic rx_s2_reg;
    logic rx_prev_reg;

    function automatic logic [2:0] state_code(input cmc_state_t s);
        case (s)
            CMC_ST_NORMAL: state_code = CMC_OP_NORMAL;
            CMC_ST_SLEEP: state_code = CMC_OP_SLEEP;
            CMC_ST_LISTEN: state_code = CMC_OP_LISTEN;
            CMC_ST_LOOP: state_code = CMC_OP_LOOP;
            default: state_code = CMC_OP_CONFIG;
        endcase
    endfunction : state_code

    function automatic cmc_state_t code_state(input logic [2:0] c);
        case (c)
            CMC_OP_NORMAL: code_state = CMC_ST_NORMAL;
            CMC_OP_SLEEP: code_state = CMC_ST_SLEEP;
            CMC_OP_LISTEN: code_state = CMC_ST_LISTEN;
            CMC_OP_LOOP: code_state = CMC_ST_LOOP;
            default: code_state = CMC_ST_CONFIG;
        endcase
    endfunction : code_state

    ////////////////////////////////////////////////////////////////////
    // Bus pin synchroniser
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rx_s1_reg <= 1'b1;
            rx_s2_reg <= 1'b1;
            rx_prev_reg <= 1'b1;
        end else begin
            rx_s1_reg <= bus_rx_pin;
            rx_s2_reg <= rx_s1_reg;
            rx_prev_reg <= rx_s2_reg;
        end
    end

    logic rx_fall;
    assign rx_fall = rx_prev_reg & ~rx_s2_reg;

    ////////////////////////////////////////////////////////////////////
    // APB decode
    logic wr_en;
    logic cfg_ok;
    logic in_sleep;
    logic in_flt;
    logic [3:0] flt_idx;
    assign wr_en = apb_req.psel & apb_req.penable & apb_req.pwrite
        & apb_rsp.pready;
    assign cfg_ok = (state_reg == CMC_ST_CONFIG);
    assign in_sleep = (state_reg == CMC_ST_SLEEP);
    assign in_flt = (apb_req.paddr >= CMC_OFF_FLT)
        && (apb_req.paddr <= CMC_OFF_FLT_END);
    assign flt_idx = apb_req.paddr[5:2];

    logic [31:0] rd_data;
    logic rd_err;
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_err = 1'b0;
        if (apb_req.paddr == CMC_OFF_CTRL) begin
            rd_data[CMC_REQ_LSB +: 3] = op_mode_request;
            rd_data[CMC_MASK3_BIT] = mask_third_reg;
            rd_data[CMC_WIE_BIT] = wake_irq_enable;
            rd_data[CMC_WDIS_BIT] = wake_disable;
            rd_data[CMC_FM_LSB +: 2] = func_mode_reg;
        end else if (apb_req.paddr == CMC_OFF_STAT) begin
            rd_data[CMC_STAT_LSB +: 3] = state_code(state_reg);
            rd_data[CMC_WFLAG_BIT] = wake_flag;
            rd_data[CMC_FLEN_LSB +: 4] = fifo_len;
            rd_data[CMC_WPTR_LSB +: 4] = fifo_wr_reg;
        end else if (apb_req.paddr == CMC_OFF_RXB) begin
            rd_data[3:0] = rx_buffer_mode_bits;
            rd_data[CMC_DFL_LSB +: 5] = dfl_reg;
        end else if (apb_req.paddr == CMC_OFF_BSEL) begin
            rd_data[CMC_NPROG-1:0] = tx_en_reg;
        end else if (in_flt && apb_req.paddr[1:0] == 2'h0) begin
            rd_data[6:0] = flt_link_reg[flt_idx];
        end else begin
            rd_err = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            apb_rsp <= '0;
        end else begin
            apb_rsp.pready <= apb_req.psel & ~apb_req.penable;
            apb_rsp.pslverr <= apb_req.psel & ~apb_req.penable & rd_err;
            if (apb_req.psel && !apb_req.penable) begin
                apb_rsp.prdata <= apb_req.pwrite ? 32'h0000_0000 : rd_data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Configuration registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            func_mode_reg <= CMC_FM_LEGACY;
            wake_disable <= 1'b0;
            wake_irq_enable <= 1'b0;
            mask_third_reg <= 1'b0;
            rx_buffer_mode_bits <= 4'h0;
            tx_en_reg <= CMC_BSEL_RST;
            dfl_reg <= 5'h00;
        end else if (wr_en) begin
            if (apb_req.paddr == CMC_OFF_CTRL) begin
                wake_disable <= apb_req.pwdata[CMC_WDIS_BIT];
                wake_irq_enable <= apb_req.pwdata[CMC_WIE_BIT];
                if (cfg_ok) begin
                    func_mode_reg <= apb_req.pwdata[CMC_FM_LSB +: 2];
                    mask_third_reg <= apb_req.pwdata[CMC_MASK3_BIT];
                end
            end else if (apb_req.paddr == CMC_OFF_RXB) begin
                rx_buffer_mode_bits <= apb_req.pwdata[3:0];
                if (cfg_ok) begin
                    // Clamp to 18 bits
                    dfl_reg <= (apb_req.pwdata[CMC_DFL_LSB +: 5]
                        > CMC_DFL_MAX) ? CMC_DFL_MAX
                        : apb_req.pwdata[CMC_DFL_LSB +: 5];
                end
            end else if (apb_req.paddr == CMC_OFF_BSEL && cfg_ok) begin
                tx_en_reg <= apb_req.pwdata[CMC_NPROG-1:0];
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < CMC_NFLT; i++) begin
                flt_link_reg[i] <= 7'h00;
            end
        end else if (wr_en && in_flt && cfg_ok) begin
            flt_link_reg[flt_idx] <= apb_req.pwdata[6:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Idle bus detector: consecutive recessive bits
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            idle_cnt_reg <= 4'h0;
        end else if (!rx_s2_reg) begin
            idle_cnt_reg <= 4'h0;
        end else if (eng.bit_tick && idle_cnt_reg != CMC_IDLE_BITS) begin
            idle_cnt_reg <= idle_cnt_reg + 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Operating mode state machine
    logic busy;
    logic wake_now;
    cmc_state_t target;
    assign busy = eng.tx_busy | eng.rx_busy;
    assign target = code_state(op_mode_request);
    assign wake_now = in_sleep & rx_fall & ~wake_disable;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= CMC_ST_CONFIG;
            prev_reg <= CMC_ST_CONFIG;
            op_mode_request <= CMC_CTRL_RST[7:5];
        end else begin
            if (wake_now) begin
                state_reg <= prev_reg;
                op_mode_request <= state_code(prev_reg);
            end else begin
                if (wr_en && apb_req.paddr == CMC_OFF_CTRL) begin
                    op_mode_request <= apb_req.pwdata[CMC_REQ_LSB +: 3];
                end
                if (target != state_reg && !eng.tx_pending) begin
                    case (target)
                        CMC_ST_SLEEP: begin
                            if (!busy || idle_cnt_reg == CMC_IDLE_BITS) begin
                                prev_reg <= state_reg;
                                state_reg <= CMC_ST_SLEEP;
                            end
                        end
                        CMC_ST_CONFIG: begin
                            if (!busy) begin
                                state_reg <= CMC_ST_CONFIG;
                            end
                        end
                        default: begin
                            state_reg <= target;
                        end
                    endcase
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Wake flag, write one to clear, set wins
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wake_flag <= 1'b0;
        end else if (wake_now) begin
            wake_flag <= 1'b1;
        end else if (wr_en && apb_req.paddr == CMC_OFF_STAT
                && apb_req.pwdata[CMC_WFLAG_BIT]) begin
            wake_flag <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Pin and engine controls
    logic listen_enter;
    assign listen_enter = (target == CMC_ST_LISTEN)
        && (state_reg != CMC_ST_LISTEN) && !eng.tx_pending;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bus_transmit_pin <= 1'b1;
            bus_tx_oe <= 1'b0;
            eng_rx_bit <= 1'b1;
            eng_tx_en <= 1'b0;
            eng_ack_en <= 1'b0;
            eng_loopback <= 1'b0;
            eng_clk_run <= 1'b1;
            err_cnt_clear <= 1'b0;
            err_cnt_hold <= 1'b1;
            wake_irq <= 1'b0;
        end else begin
            // Recessive unless normal mode
            bus_transmit_pin <= (state_reg == CMC_ST_NORMAL)
                ? eng.tx_bit : 1'b1;
            // Released to port function in loopback and config
            bus_tx_oe <= (state_reg != CMC_ST_LOOP)
                && (state_reg != CMC_ST_CONFIG);
            eng_rx_bit <= (state_reg == CMC_ST_LOOP)
                ? eng.tx_bit : rx_s2_reg;
            eng_tx_en <= (state_reg == CMC_ST_NORMAL)
                || (state_reg == CMC_ST_LOOP);
            eng_ack_en <= (state_reg == CMC_ST_NORMAL);
            eng_loopback <= (state_reg == CMC_ST_LOOP);
            eng_clk_run <= !in_sleep;
            err_cnt_clear <= listen_enter
                || (target == CMC_ST_CONFIG && !cfg_ok);
            err_cnt_hold <= in_sleep || cfg_ok
                || (state_reg == CMC_ST_LISTEN);
            wake_irq <= wake_flag && wake_irq_enable
                && !wake_disable;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // FIFO length: stops at first transmit programmable buffer
    logic [3:0] flen;
    always_comb begin
        flen = CMC_FIFO_MAX;
        for (int i = CMC_NPROG - 1; i >= 0; i--) begin
            if (tx_en_reg[i]) begin
                flen = CMC_BUF_PROG0 + 4'(i);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Acceptance routing
    function automatic logic buf_is_rx(input logic [3:0] b,
            input logic [CMC_NPROG-1:0] txe);
        logic r;
        r = 1'b0;
        if (b < CMC_BUF_PROG0) begin
            r = 1'b1;
        end else if (b < CMC_FIFO_MAX) begin
            r = !txe[3'(b - CMC_BUF_PROG0)];
        end
        buf_is_rx = r;
    endfunction : buf_is_rx

    logic hit_ok;
    logic [3:0] hit_buf;
    logic [3:0] fidx;
    always_comb begin
        hit_ok = 1'b0;
        hit_buf = 4'h0;
        fidx = 4'h0;
        if (func_mode_reg == CMC_FM_LEGACY) begin
            // Filters 0-1 to buffer 0, 2-5 to buffer 1
            if (eng.flt_hit[1:0] != 2'h0) begin
                hit_ok = 1'b1;
            end else if (eng.flt_hit[5:2] != 4'h0) begin
                hit_ok = 1'b1;
                hit_buf = 4'h1;
            end
        end else begin
            for (int i = CMC_NFLT - 1; i >= 0; i--) begin
                fidx = 4'(i);
                // Filter 15 acts as third mask when selected
                if (eng.flt_hit[i] && flt_link_reg[i][CMC_FL_EN_BIT]
                        && !(fidx == 4'hf && mask_third_reg)
                        && buf_is_rx(flt_link_reg[i][3:0], tx_en_reg)
                        && flt_link_reg[i][3:0] < flen) begin
                    hit_ok = 1'b1;
                    hit_buf = flt_link_reg[i][3:0];
                end
            end
        end
    end

    // Legacy buffer in error recognition takes invalid frames
    logic errrec_ok;
    logic [3:0] errrec_buf;
    always_comb begin
        errrec_ok = 1'b0;
        errrec_buf = 4'h0;
        if (func_mode_reg == CMC_FM_LEGACY) begin
            if (rx_buffer_mode_bits[1:0] == CMC_RXM_ERRREC) begin
                errrec_ok = 1'b1;
            end else if (rx_buffer_mode_bits[3:2] == CMC_RXM_ERRREC) begin
                errrec_ok = 1'b1;
                errrec_buf = 4'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            store_valid <= 1'b0;
            store_buf <= 4'h0;
            fifo_wr_reg <= 4'h0;
        end else begin
            store_valid <= 1'b0;
            if (func_mode_reg != CMC_FM_FIFO) begin
                fifo_wr_reg <= 4'h0;
            end
            // Nothing stored in sleep or config; wake frame dropped
            if (eng.msg_done && !in_sleep && !cfg_ok) begin
                if (!eng.msg_ok) begin
                    if (state_reg == CMC_ST_LISTEN) begin
                        store_valid <= 1'b1;
                        store_buf <= 4'h0;
                    end else if (errrec_ok) begin
                        store_valid <= 1'b1;
                        store_buf <= errrec_buf;
                    end
                end else if (hit_ok) begin
                    store_valid <= 1'b1;
                    if (func_mode_reg == CMC_FM_FIFO) begin
                        store_buf <= fifo_wr_reg;
                        fifo_wr_reg <= (fifo_wr_reg + 4'h1 >= flen)
                            ? 4'h0 : fifo_wr_reg + 4'h1;
                    end else begin
                        store_buf <= hit_buf;
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Routing fields to the filter engine
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            flt_mask_sel <= 32'h0000_0000;
            data_filter_length <= 5'h00;
            fifo_len <= CMC_FIFO_MAX;
        end else begin
            for (int i = 0; i < CMC_NFLT; i++) begin
                flt_mask_sel[2*i +: 2] <=
                    flt_link_reg[i][CMC_FL_MSK_LSB +: 2];
            end
            data_filter_length <= (func_mode_reg == CMC_FM_LEGACY)
                ? 5'h00 : dfl_reg;
            fifo_len <= flen;
        end
    end

endmodule : cmc_mode_ctrl

`default_nettype wire

/* File: cmc_pkg.sv */
package cmc_pkg;

    ////////////////////////////////////////////////////////////////////
    // Register offsets (byte addresses)
    localparam logic [7:0] CMC_OFF_CTRL = 8'h00;
    localparam logic [7:0] CMC_OFF_STAT = 8'h04;
    localparam logic [7:0] CMC_OFF_RXB = 8'h08;
    localparam logic [7:0] CMC_OFF_BSEL = 8'h0c;
    localparam logic [7:0] CMC_OFF_FLT = 8'h40;
    localparam logic [7:0] CMC_OFF_FLT_END = 8'h7c;

    // Control register fields
    localparam int CMC_REQ_LSB = 5;
    localparam int CMC_FM_LSB = 0;
    localparam int CMC_WDIS_BIT = 2;
    localparam int CMC_WIE_BIT = 3;
    localparam int CMC_MASK3_BIT = 4;
    // Status register fields
    localparam int CMC_STAT_LSB = 5;
    localparam int CMC_WFLAG_BIT = 0;
    localparam int CMC_FLEN_LSB = 8;
    localparam int CMC_WPTR_LSB = 12;
    // Filter link fields, then data filter length field of the RXB register
    localparam int CMC_FL_MSK_LSB = 4;
    localparam int CMC_FL_EN_BIT = 6;
    localparam int CMC_DFL_LSB = 8;

    ////////////////////////////////////////////////////////////////////
    // Mode request / status codes
    localparam logic [2:0] CMC_OP_NORMAL = 3'h0;
    localparam logic [2:0] CMC_OP_SLEEP = 3'h1;
    localparam logic [2:0] CMC_OP_LOOP = 3'h2;
    localparam logic [2:0] CMC_OP_LISTEN = 3'h3;
    localparam logic [2:0] CMC_OP_CONFIG = 3'h4;
    localparam logic [1:0] CMC_RXM_ERRREC = 2'h3;
    localparam logic [1:0] CMC_FM_LEGACY = 2'h0;
    localparam logic [1:0] CMC_FM_ENH = 2'h1;
    localparam logic [1:0] CMC_FM_FIFO = 2'h2;

    // Reset values
    localparam logic [7:0] CMC_CTRL_RST = 8'h80;
    localparam logic [5:0] CMC_BSEL_RST = 6'h00;

    // Counts and sizes
    localparam logic [3:0] CMC_IDLE_BITS = 4'hb;
    localparam logic [4:0] CMC_DFL_MAX = 5'h12;
    localparam int CMC_NFLT = 16;
    localparam int CMC_NPROG = 6;
    localparam logic [3:0] CMC_FIFO_MAX = 4'h8;
    localparam logic [3:0] CMC_BUF_PROG0 = 4'h2;

    ////////////////////////////////////////////////////////////////////
    typedef enum logic [4:0] {
        CMC_ST_CONFIG = 5'b00001,
        CMC_ST_NORMAL = 5'b00010,
        CMC_ST_SLEEP = 5'b00100,
        CMC_ST_LISTEN = 5'b01000,
        CMC_ST_LOOP = 5'b10000
    } cmc_state_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } cmc_apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } cmc_apb_rsp_t;

    // Protocol engine status, same clock
    typedef struct packed {
        logic tx_busy;
        logic rx_busy;
        logic tx_pending;
        logic bit_tick;
        logic tx_bit;
        logic msg_done;
        logic msg_ok;
        logic [15:0] flt_hit;
    } cmc_eng_t;

endpackage : cmc_pkg

/* File: tb_can_mode_and_buffer_config.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_can_mode_and_buffer_config;
    import cmc_pkg::*;
    logic clk, rstn, node_dom, rnd, tx, oe, rx, irq, lb, ten, aen, crun, hold;
    logic er, sv, rxb, lbv, clr;
    logic [3:0] fl, sb;
    logic [4:0] dfl, dv, lo;
    logic [5:0] bs;
    logic [31:0] rd, ms;
    cmc_apb_req_t req;
    cmc_apb_rsp_t rsp;
    cmc_eng_t eng;
    int errors, n_checks, i, nclr;
    cmc_mode_ctrl u_dut (.clk(clk), .rstn(rstn), .apb_req(req), .apb_rsp(rsp),
        .bus_rx_pin(rx), .bus_transmit_pin(tx), .bus_tx_oe(oe), .eng(eng),
        .eng_rx_bit(rxb), .eng_tx_en(ten), .eng_ack_en(aen), .eng_loopback(lb),
        .eng_clk_run(crun), .err_cnt_clear(clr), .err_cnt_hold(hold),
        .flt_mask_sel(ms), .data_filter_length(dfl), .store_valid(sv),
        .store_buf(sb), .fifo_len(fl), .wake_irq(irq));
    cmc_bus_model u_bus (.tx_pin(tx), .tx_oe(oe), .node_dom(node_dom),
        .rx_pin(rx));
    ////////////////////////////////////////////////////////////////////
    task end_sim;
        if (errors == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : end_sim
    task chk(input string n, input logic [31:0] e, input logic [31:0] s);
        n_checks++;
        if (s !== e) begin
            errors++;
            $display("FAIL %s exp %h got %h", n, e, s);
        end
    endtask : chk
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk);
        req.penable <= 1'b1;
        do @(posedge clk); while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        er = rsp.pslverr;
        req <= '0;
    endtask : apb
    function logic [5:0] outs(input logic [2:0] m);
        case (m)
            CMC_OP_NORMAL: return 6'h35;
            CMC_OP_LOOP: return 6'h2c;
            CMC_OP_LISTEN: return 6'h07;
            CMC_OP_SLEEP: return 6'h03;
            default: return 6'h06;
        endcase
    endfunction : outs
    function logic [3:0] fexp(input logic [5:0] b);
        for (int k = 0; k < 6; k++) if (b[k]) return 4'(k + 2);
        return CMC_FIFO_MAX;
    endfunction : fexp
    task go(input logic [2:0] m);
        apb(1'b1, CMC_OFF_CTRL, {24'h0, m, lo});
        rd = '1;
        for (int k = 0; k < 40 && rd[7:5] !== m; k++) begin
            apb(1'b0, CMC_OFF_STAT, 0);
        end
        chk("mode", m, rd[7:5]);
        chk("outs", outs(m), {ten, aen, lb, crun, hold, oe});
    endtask : go
    task msg(input logic ok, input logic [15:0] h, input logic v,
            input logic [3:0] b);
        @(posedge clk);
        eng.msg_done <= 1'b1;
        eng.msg_ok <= ok;
        eng.flt_hit <= h;
        @(posedge clk);
        eng.msg_done <= 1'b0;
        @(posedge clk);
        chk("stv", v, sv);
        if (v) chk("stb", b, sb);
    endtask : msg
    ////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) eng.tx_bit <= rnd ? 1'($urandom) : 1'b1;
    always @(posedge clk) if (clr === 1'b1) nclr <= nclr + 1;
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        end_sim;
    end
    initial begin
        rstn = 1'b0;
        node_dom = 1'b0;
        rnd = 1'b0;
        req = '0;
        eng = '0;
        lo = 5'h0a;
        void'($urandom(93));
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        apb(1'b0, CMC_OFF_CTRL, 0);
        chk("ctrl", CMC_CTRL_RST, rd[7:0]);
        apb(1'b0, CMC_OFF_STAT, 0);
        chk("stat", CMC_OP_CONFIG, rd[7:5]);
        apb(1'b0, 8'h20, 0);
        chk("slverr", 1, er);
        for (i = 0; i < 5; i++) begin
            bs = i == 0 ? 6'h00 : i == 1 ? 6'h01 : 6'($urandom);
            dv = i == 0 ? 5'h12 : i == 1 ? 5'h13 : 5'($urandom);
            apb(1'b1, CMC_OFF_BSEL, {26'h0, bs});
            apb(1'b1, CMC_OFF_RXB, {19'h0, dv, 8'h00});
            apb(1'b1, CMC_OFF_CTRL, 32'h8a);
            repeat (2) @(posedge clk);
            chk("fifo", fexp(bs), fl);
            chk("dfl", dv > CMC_DFL_MAX ? CMC_DFL_MAX : dv, dfl);
        end
        apb(1'b1, CMC_OFF_FLT + 8'h0c, 32'h50);
        rnd = 1'b1;
        go(CMC_OP_NORMAL);
        chk("msk", 2'h1, ms[7:6]);
        msg(1'b1, 16'h0008, 1'b1, 4'h0);
        msg(1'b1, 16'h0008, 1'b1, 4'h1);
        go(CMC_OP_LOOP);
        @(posedge clk);
        lbv = eng.tx_bit;
        @(posedge clk);
        chk("lbk", lbv, rxb);
        go(CMC_OP_LISTEN);
        chk("clr", 1, nclr);
        msg(1'b0, 16'h0000, 1'b1, 4'h0);
        go(CMC_OP_NORMAL);
        eng.tx_pending <= 1'b1;
        apb(1'b1, CMC_OFF_CTRL, {24'h0, CMC_OP_LISTEN, 5'h0a});
        repeat (5) @(posedge clk);
        apb(1'b0, CMC_OFF_STAT, 0);
        chk("pend", CMC_OP_NORMAL, rd[7:5]);
        eng.tx_pending <= 1'b0;
        go(CMC_OP_LISTEN);
        go(CMC_OP_NORMAL);
        rnd = 1'b0;
        repeat (4) @(posedge clk);
        go(CMC_OP_SLEEP);
        chk("pin", 1, tx);
        msg(1'b1, 16'hffff, 1'b0, 4'h0);
        node_dom <= 1'b1;
        repeat (4) @(posedge clk);
        node_dom <= 1'b0;
        repeat (3) @(posedge clk);
        apb(1'b0, CMC_OFF_STAT, 0);
        chk("wake", {CMC_OP_NORMAL, 1'b1}, {rd[7:5], rd[0]});
        chk("irq", 1, irq);
        apb(1'b1, CMC_OFF_STAT, 1);
        repeat (2) @(posedge clk);
        chk("irq clr", 0, irq);
        go(CMC_OP_CONFIG);
        lo = 5'h08;
        go(CMC_OP_NORMAL);
        chk("dfl0", 0, dfl);
        apb(1'b1, CMC_OFF_RXB, 32'h0000_000c);
        msg(1'b0, 16'h0000, 1'b1, 4'h1);
        msg(1'b1, 16'h0001, 1'b1, 4'h0);
        msg(1'b1, 16'h0004, 1'b1, 4'h1);
        end_sim;
    end
endmodule : tb_can_mode_and_buffer_config
`default_nettype wire
